// ---- verilog/bfs_pkg.sv ----
/*
  shared constants and carrier types for the bit-stream and squelch logic.
  assumes a 125 MHz system clock and a bit strobe from the modem.
*/
// Summary of operation
// - two squelch modes, each with its own presence threshold, chosen by port.
// - detection mode during cable-type detection, presence above its threshold.
// - operating mode while waiting for packets, operating threshold used.
// - channel idle while squelch below operating threshold, busy otherwise.
// - supply noise alone never flags busy; only in-band signal above threshold.
// - dead-battery port can send endless alternating bits; last preamble may be short.
// - keep sending until system ready for capabilities or supply at safe zero.
// - flag stream detected after 128 consecutive alternating bits.
// - after detection, flag stopped when squelch closed for quiet interval.
// - stream bits are raw preamble bits, bypassing the 4b5b encoder.
package bfs_pkg;
  localparam int unsigned BFS_CLK_HZ = 125000000;
  localparam int unsigned BFS_PREAMBLE_BITS = 64;
  localparam int unsigned BFS_DETECT_BITS = 128;
  // quiet interval, 1 to 3 ms allowed; 2 ms chosen
  localparam int unsigned BFS_QUIET_US = 2000;
  localparam int unsigned BFS_QUIET_CYC = BFS_QUIET_US * (BFS_CLK_HZ / 1000000);
  // in-band presence must persist this many cycles to count as busy
  localparam int unsigned BFS_BUSY_FILT_CYC = 8;

  typedef enum logic [0:0] {
    BFS_MODE_DETECT = 1'b0,
    BFS_MODE_OPERATE = 1'b1
  } bfs_mode_t;

  typedef struct packed {
    logic detect_mode_squelch_open;
    logic operate_mode_squelch_open;
  } bfs_squelch_t;

  typedef struct packed {
    logic valid;
    logic data;
  } bfs_bit_t;
endpackage

// ---- verilog/bfs_filter.sv ----
/*
  persistence filter: output follows input only after it holds steady.
  assumes input already synchronised to i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module bfs_filter #(
  parameter int unsigned CYCLES = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // level in and out
  input wire logic i_level,
  output logic o_level
);
  localparam int unsigned W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_reg, cnt_next;
  logic out_reg, out_next;

  always_comb begin
    cnt_next = cnt_reg;
    out_next = out_reg;
    if (i_level == out_reg) begin
      cnt_next = '0;
    end else if (cnt_reg == W'(CYCLES - 1)) begin
      cnt_next = '0;
      out_next = i_level;
    end else begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign o_level = out_reg;
endmodule
`default_nettype wire

// ---- verilog/bfs_bitstream.sv ----
/*
  squelch mode selection, idle/busy, alternating-bit stream transmit,
  stream detection and end-of-stream indication.
  assumes analog squelch comparators and supply-level flags arrive
  asynchronously; received bits come with a strobe on i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module bfs_bitstream
  import bfs_pkg::*;
#(
  parameter int unsigned DETECT_BITS = BFS_DETECT_BITS,
  parameter int unsigned QUIET_CYC = BFS_QUIET_CYC,
  parameter int unsigned BUSY_FILT_CYC = BFS_BUSY_FILT_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // port control
  input wire logic i_cable_detect_active,
  input wire logic i_stream_tx_enable,
  input wire logic i_system_ready,
  // analog status pins
  input wire bfs_squelch_t i_squelch,
  input wire logic i_supply_safe_zero,
  // bit timing and received bits
  input wire logic i_bit_tick,
  input wire bfs_bit_t i_rx_bit,
  // receiver status
  output bfs_mode_t o_squelch_mode,
  output logic o_signal_present,
  output logic o_channel_busy,
  output logic o_stream_detected,
  output logic o_stream_stopped,
  // raw transmit bits
  output bfs_bit_t o_tx_bit,
  output logic o_tx_active
);
  // counters sized to hold their terminal counts
  localparam int unsigned DW = $clog2(DETECT_BITS + 1);
  localparam int unsigned QW = $clog2(QUIET_CYC + 1);

  // two-flop synchronisers for the analog inputs
  logic [2:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
  logic det_open, op_open, safe_zero, op_filt;

  always_comb begin
    sync1_next = {i_supply_safe_zero, i_squelch.operate_mode_squelch_open,
                  i_squelch.detect_mode_squelch_open};
    sync2_next = sync1_reg;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  // only the second stage is read; the first may still be settling
  assign det_open = sync2_reg[0];
  assign op_open = sync2_reg[1];
  assign safe_zero = sync2_reg[2];

  // short glitches of supply ripple leaking past the band filter rejected
  // busy and operate-mode presence share this one filtered level
  bfs_filter #(
    .CYCLES(BUSY_FILT_CYC)
  ) u_busy_filter (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_level(op_open),
    .o_level(op_filt)
  );

  // mode, presence and busy
  bfs_mode_t mode_reg, mode_next;
  logic present_reg, present_next, busy_reg, busy_next;

  // presence follows the mode of the previous cycle, one cycle behind
  // detect comparator read unfiltered: cable detection wants speed
  always_comb begin
    mode_next = i_cable_detect_active ? BFS_MODE_DETECT
                                      : BFS_MODE_OPERATE;
    present_next = (mode_reg == BFS_MODE_DETECT) ? det_open
                                                 : op_filt;
    busy_next = op_filt;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      // out of reset the receiver watches for packets
      mode_reg <= BFS_MODE_OPERATE;
      present_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      present_reg <= present_next;
      busy_reg <= busy_next;
    end
  end

  // transmit: raw alternating bits, never through the symbol encoder
  logic tx_act_reg, tx_act_next, tx_data_reg, tx_data_next;
  logic tx_valid_reg, tx_valid_next;
  logic tx_halt, tx_start, tx_shift;

  // a halt beats a start or a tick landing in the same cycle
  assign tx_halt = i_system_ready || safe_zero;
  assign tx_start = i_stream_tx_enable && !tx_act_reg;
  // stopping mid-preamble is fine: the last one may be short
  assign tx_shift = tx_act_reg && i_bit_tick && !tx_halt;

  always_comb begin
    tx_act_next = tx_act_reg;
    tx_data_next = tx_data_reg;
    tx_valid_next = 1'b0;
    if (tx_halt) begin
      tx_act_next = 1'b0;
    end else if (tx_start) begin
      tx_act_next = 1'b1;
      // seed so that the first bit on the wire is a one
      tx_data_next = 1'b0;
    end
    if (tx_shift) begin
      tx_valid_next = 1'b1;
      tx_data_next = ~tx_data_reg;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tx_act_reg <= 1'b0;
      tx_data_reg <= 1'b0;
      tx_valid_reg <= 1'b0;
    end else begin
      tx_act_reg <= tx_act_next;
      tx_data_reg <= tx_data_next;
      tx_valid_reg <= tx_valid_next;
    end
  end

  // receive detection and quiet timing
  logic [DW-1:0] run_reg, run_next;
  logic last_reg, last_next, have_reg, have_next;
  logic det_reg, det_next, stop_reg, stop_next;
  logic [QW-1:0] quiet_reg, quiet_next;
  logic rx_repeat, run_full, quiet_done;

  // first bit after the squelch opens has no partner and starts a run
  assign rx_repeat = have_reg && (i_rx_bit.data == last_reg);
  assign run_full = (run_reg == DW'(DETECT_BITS - 1));
  // reopening resets the timer: a stop needs one unbroken quiet stretch
  assign quiet_done = (quiet_reg == QW'(QUIET_CYC - 1));

  always_comb begin
    run_next = run_reg;
    last_next = last_reg;
    have_next = have_reg;
    det_next = det_reg;
    stop_next = stop_reg;
    quiet_next = quiet_reg;
    // once detected, bits are ignored and only the quiet timer runs
    if (!det_reg) begin
      if (!op_open) begin
        run_next = '0;
        have_next = 1'b0;
      end else if (i_rx_bit.valid) begin
        last_next = i_rx_bit.data;
        have_next = 1'b1;
        if (rx_repeat) begin
          // the repeated bit opens a fresh run of one
          run_next = DW'(1);
        end else if (run_full) begin
          run_next = '0;
          det_next = 1'b1;
          stop_next = 1'b0;
          quiet_next = '0;
        end else begin
          run_next = run_reg + 1'b1;
        end
      end
    end else if (op_open) begin
      quiet_next = '0;
    end else if (quiet_done) begin
      quiet_next = '0;
      det_next = 1'b0;
      stop_next = 1'b1;
      have_next = 1'b0;
    end else begin
      quiet_next = quiet_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      run_reg <= '0;
      last_reg <= 1'b0;
      have_reg <= 1'b0;
      det_reg <= 1'b0;
      stop_reg <= 1'b0;
      quiet_reg <= '0;
    end else begin
      run_reg <= run_next;
      last_reg <= last_next;
      have_reg <= have_next;
      det_reg <= det_next;
      stop_reg <= stop_next;
      quiet_reg <= quiet_next;
    end
  end

  // every output is a register, so nothing combinational leaves
  assign o_squelch_mode = mode_reg;
  assign o_signal_present = present_reg;
  assign o_channel_busy = busy_reg;
  assign o_stream_detected = det_reg;
  assign o_stream_stopped = stop_reg;
  assign o_tx_bit = '{valid: tx_valid_reg, data: tx_data_reg};
  assign o_tx_active = tx_act_reg;
endmodule
`default_nettype wire

// ---- tb/bfs_partner.sv ----
/* far-side port model: alternating bit bursts on the supply wire.
   assumes the bench pulses i_go for one cycle with count and repeat. */
`timescale 1ns/1ps
`default_nettype none
module bfs_partner
  import bfs_pkg::*;
(
  // control
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [7:0] i_bits,
  input wire logic [7:0] i_dup,
  // wire side
  output var bfs_squelch_t o_squelch,
  output var bfs_bit_t o_rx_bit,
  output logic o_busy
);
  logic last = 1'b1;
  initial begin
    o_squelch = '0;
    o_rx_bit = '0;
    o_busy = 1'b0;
    forever begin
      @(posedge i_clk iff i_go);
      o_busy = 1'b1;
      @(negedge i_clk);
      o_squelch = 2'h3;
      repeat (12) @(negedge i_clk);
      for (int n = 0; n < i_bits; n++) begin
        if (n != i_dup) last = !last;
        o_rx_bit = {1'b1, last};
        @(negedge i_clk);
        // stale data inverted so it is never mistaken for a bit
        o_rx_bit = {1'b0, !last};
        repeat (3) @(negedge i_clk);
      end
      repeat (4) @(negedge i_clk);
      o_squelch = '0;
      last = 1'b1;
      o_busy = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- tb/bfs_bitstream_asserts.sv ----
/* port-level checks of the bit-stream block.
   assumes binding to bfs_bitstream, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module bfs_bitstream_asserts
  import bfs_pkg::*;
#(
  parameter int unsigned QUIET_CYC = BFS_QUIET_CYC,
  parameter int unsigned BUSY_FILT_CYC = BFS_BUSY_FILT_CYC
) (
  // inputs
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_cable_detect_active,
  input wire logic i_system_ready,
  input wire bfs_squelch_t i_squelch,
  input wire logic i_supply_safe_zero,
  input wire logic i_bit_tick,
  input wire bfs_bit_t i_rx_bit,
  // outputs
  input wire bfs_mode_t o_squelch_mode,
  input wire logic o_channel_busy,
  input wire logic o_stream_detected,
  input wire logic o_stream_stopped,
  input wire bfs_bit_t o_tx_bit,
  input wire logic o_tx_active
);
  int open_reg, open_next, shut_reg, shut_next;
  logic sent_reg, sent_next, last_reg, last_next;
  always_comb begin
    open_next = i_squelch.operate_mode_squelch_open ? open_reg + 1 : 0;
    shut_next = i_squelch.operate_mode_squelch_open ? 0 : shut_reg + 1;
    sent_next = o_tx_active && (sent_reg || o_tx_bit.valid);
    last_next = o_tx_bit.valid ? o_tx_bit.data : last_reg;
  end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      open_reg <= 0;
      shut_reg <= 0;
      sent_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      open_reg <= open_next;
      shut_reg <= shut_next;
      sent_reg <= sent_next;
      last_reg <= last_next;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_halt;
    i_system_ready [*2];
  endsequence
  a_mode_follow: assert property (!$past(i_reset) |->
    o_squelch_mode == !$past(i_cable_detect_active)) else $error("mode");
  a_busy_noise: assert property ($rose(o_channel_busy) |->
    open_reg >= BUSY_FILT_CYC) else $error("busy too early");
  a_busy_idle: assert property (shut_reg > BUSY_FILT_CYC + 6 |->
    !o_channel_busy) else $error("busy while closed");
  a_busy_set: assert property (open_reg > BUSY_FILT_CYC + 6 |->
    o_channel_busy) else $error("idle while open");
  a_detect_bit: assert property ($rose(o_stream_detected) |->
    $past(i_rx_bit.valid)) else $error("detect without bit");
  a_stop_quiet: assert property ($rose(o_stream_stopped) |->
    shut_reg >= QUIET_CYC && $past(o_stream_detected)) else $error("stop");
  a_tx_ready: assert property (s_halt |-> !o_tx_active)
    else $error("tx after ready");
  a_tx_safe: assert property (i_supply_safe_zero [*4] |->
    !o_tx_active) else $error("tx at safe zero");
  a_tx_tick: assert property (o_tx_bit.valid |-> $past(i_bit_tick))
    else $error("tx bit off tick");
  a_tx_alt: assert property (o_tx_bit.valid |->
    o_tx_bit.data == (sent_reg ? !last_reg : 1'b1)) else $error("tx alt");
endmodule
bind bfs_bitstream bfs_bitstream_asserts #(
  .QUIET_CYC(QUIET_CYC),
  .BUSY_FILT_CYC(BUSY_FILT_CYC)
) u_chk (
  .i_clk(i_clk),
  .i_reset(i_reset),
  .i_cable_detect_active(i_cable_detect_active),
  .i_system_ready(i_system_ready),
  .i_squelch(i_squelch),
  .i_supply_safe_zero(i_supply_safe_zero),
  .i_bit_tick(i_bit_tick),
  .i_rx_bit(i_rx_bit),
  .o_squelch_mode(o_squelch_mode),
  .o_channel_busy(o_channel_busy),
  .o_stream_detected(o_stream_detected),
  .o_stream_stopped(o_stream_stopped),
  .o_tx_bit(o_tx_bit),
  .o_tx_active(o_tx_active)
);
`default_nettype wire

// ---- tb/tb.sv ----
/* self-checking bench for bfs_bitstream with a far-port model.
   assumes bfs_partner and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bfs_pkg::*;
  localparam int QUIET = 50;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic cab = 1'b0, txen = 1'b0, rdy = 1'b0, safe = 1'b0, go = 1'b0;
  logic pbusy, pres, busy, det, stp, txa;
  logic [1:0] tdiv = 2'h0;
  logic [7:0] nb = 8'h0, nd = 8'hff;
  bfs_squelch_t tsq = '0, psq;
  bfs_bit_t prx, otx;
  bfs_mode_t mode;
  int miscompares = 0, total_checks = 0;
  always #4 i_clk = !i_clk;
  always @(negedge i_clk) tdiv <= tdiv + 2'h1;
  bfs_bitstream #(.QUIET_CYC(QUIET)) dut (.i_clk(i_clk), .i_reset(i_reset),
    .i_cable_detect_active(cab), .i_stream_tx_enable(txen),
    .i_system_ready(rdy), .i_squelch(tsq | psq), .i_supply_safe_zero(safe),
    .i_bit_tick(tdiv == 2'h3), .i_rx_bit(prx), .o_squelch_mode(mode),
    .o_signal_present(pres), .o_channel_busy(busy),
    .o_stream_detected(det), .o_stream_stopped(stp), .o_tx_bit(otx),
    .o_tx_active(txa));
  bfs_partner u_far (.i_clk(i_clk), .i_go(go), .i_bits(nb), .i_dup(nd),
    .o_squelch(psq), .o_rx_bit(prx), .o_busy(pbusy));
  task automatic end_sim;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic c, input string m);
    total_checks++;
    if (c !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // by reference, so the pulse reaches the design while the task runs
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task automatic burst(input logic [7:0] b, input logic [7:0] d);
    nb = b;
    nd = d;
    step(4);
    pulse(go);
    for (int w = 0; w < 2000 && pbusy !== 1'b0; w++) step(1);
    if (pbusy !== 1'b0) begin
      miscompares++;
      $display("[ERR] %0t partner hung", $time);
      end_sim;
    end
  endtask
  task automatic t_mode;
    chk(mode === BFS_MODE_OPERATE && {pres, busy, det, stp, txa} === 5'h0,
      "reset");
    cab = 1'b1;
    tsq = 2'h2;
    step(6);
    chk(mode === BFS_MODE_DETECT && pres === 1'b1, "detect");
    chk(busy === 1'b0, "busy on weak level");
    cab = 1'b0;
    step(2);
    chk(mode === BFS_MODE_OPERATE && pres === 1'b0, "operate");
    tsq = 2'h1;
    step(5);
    tsq = '0;
    step(15);
    chk(busy === 1'b0, "glitch busy");
    tsq = 2'h1;
    step(15);
    chk(busy === 1'b1 && pres === 1'b1, "busy");
    tsq = '0;
    step(15);
    chk(busy === 1'b0, "idle");
    $display("test mode done");
  endtask
  task automatic t_stream;
    // the second burst would complete the run if closing did not clear it
    burst(8'd191, 8'd64);
    burst(8'd100, 8'hff);
    chk(det === 1'b0, "run not restarted");
    burst(8'd128, 8'hff);
    chk(det === 1'b1 && stp === 1'b0, "detect");
    step(QUIET - 10);
    chk(det === 1'b1 && stp === 1'b0, "early stop");
    step(20);
    chk(stp === 1'b1 && det === 1'b0, "stopped");
    $display("test stream done");
  endtask
  task automatic t_tx;
    logic e;
    e = 1'b1;
    pulse(txen);
    chk(txa === 1'b1, "tx start");
    for (int n = 0; n < 70; n++) begin
      for (int w = 0; w < 8 && otx.valid !== 1'b1; w++) step(1);
      chk(otx.valid === 1'b1 && otx.data === e, "tx bit");
      // a missing tick is a hang: report at once
      if (otx.valid !== 1'b1) end_sim;
      e = !e;
      step(1);
    end
    rdy = 1'b1;
    step(2);
    chk(txa === 1'b0, "ready stop");
    pulse(txen);
    step(1);
    chk(txa === 1'b0, "enable refused");
    rdy = 1'b0;
    pulse(txen);
    chk(txa === 1'b1, "tx restart");
    safe = 1'b1;
    step(5);
    chk(txa === 1'b0, "safe stop");
    safe = 1'b0;
    $display("test tx done");
  endtask
  initial begin
    step(8);
    i_reset = 1'b0;
    t_mode;
    t_stream;
    t_tx;
    end_sim;
  end
endmodule
`default_nettype wire
